// file: src/imadc_pkg.sv
// imadc_pkg: offsets, field positions, reset values, states and timing
// for the i2c master address/data control block.
// assumes a 100 MHz hclk and word-aligned ahb-lite register access.
package imadc_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL     = 8'h04;
  localparam logic [7:0] OFF_INTFLAG  = 8'h10;
  localparam logic [7:0] OFF_STATUS   = 8'h14;
  localparam logic [7:0] OFF_DATA     = 8'h18;
  localparam logic [7:0] OFF_SYNCBUSY = 8'h1c;
  localparam logic [7:0] OFF_ADDR     = 8'h24;
  localparam logic [7:0] OFF_DEBUG_HALT_CONTROL  = 8'h30;

  // ==========================================================
  // field positions
  localparam int CTRL_ENABLE_BIT = 1;
  localparam int CTRL_SMEN_BIT   = 8;
  localparam int CTRL_CMD_LSB    = 16;
  localparam int CTRL_ACKACT_BIT = 18;
  localparam int ADDR_LEN_LSB    = 16;
  localparam int ADDR_WIDE_BIT   = 15;
  localparam int ADDR_HS_BIT     = 14;
  localparam int ADDR_AUTO_COUNT_ENABLE_BIT  = 13;
  localparam int ST_BUSERR_BIT   = 0;
  localparam int ST_ARBLOST_BIT  = 1;
  localparam int ST_BUS_OWNERSHIP_STATE_LSB = 4;
  localparam int ST_SCL_LOW_TIMEOUT_FLAG_BIT  = 6;
  localparam int INT_MB_BIT      = 0;
  localparam int INT_SB_BIT      = 1;
  localparam logic [31:0] ADDR_WR_MASK = 32'h00ffe7ff;

  // ==========================================================
  // reset values
  localparam logic [31:0] ADDR_RST    = 32'h00000000;
  localparam logic [7:0]  DATA_RST    = 8'h00;
  localparam logic [7:0]  DEBUG_HALT_CONTROL_RST = 8'h00;
  localparam logic [31:0] CTRL_RST    = 32'h00000000;

  // ==========================================================
  // encodings
  localparam logic [1:0] BS_UNKNOWN = 2'h0;
  localparam logic [1:0] BS_IDLE    = 2'h1;
  localparam logic [1:0] BS_OWNER   = 2'h2;
  localparam logic [1:0] BS_BUSY    = 2'h3;
  localparam logic [1:0] CMD_READ   = 2'h2;
  localparam logic [1:0] CMD_STOP   = 2'h3;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
  localparam logic [1:0] NX_RXB   = 2'h0;
  localparam logic [1:0] NX_STOP  = 2'h1;
  localparam logic [1:0] NX_START = 2'h2;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int STD_BIT_NS    = 10000;
  localparam int HS_BIT_NS     = 294;
  localparam int STD_QTR_CYC   = STD_BIT_NS / (4 * CLK_PERIOD_NS);
  localparam int HS_QTR_CYC    = HS_BIT_NS / (4 * CLK_PERIOD_NS);
  localparam int SCL_LOW_TIMEOUT_FLAG_MS    = 25;
  localparam int SCL_LOW_TIMEOUT_FLAG_CYC   = SCL_LOW_TIMEOUT_FLAG_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [1:0] SYNC_CYC = 2'h3;

  typedef enum logic [3:0] {
    S_IDLE, S_WAIT, S_START, S_TXB, S_TXACK, S_RXB, S_RXACK, S_HOLD, S_STOP
  } imadc_state_t;

endpackage : imadc_pkg

// file: src/imadc_line_if.sv
// imadc_line_if: synchronised i2c line levels and bus conditions.
// assumes one hclk domain on both sides.
`timescale 1ns/1ns
interface imadc_line_if;
  logic scl;
  logic sda;
  logic start_det;
  logic stop_det;
  modport mon  (output scl, sda, start_det, stop_det);
  modport core (input  scl, sda, start_det, stop_det);
endinterface : imadc_line_if

// file: src/imadc_line_mon.sv
// imadc_line_mon: two-flop synchronisers on scl/sda and start/stop detect.
// assumes raw pin levels that are asynchronous to hclk.
`timescale 1ns/1ns
module imadc_line_mon (
  input  wire logic   hclk,
  input  wire logic   hresetn,
  input  wire logic   scl_in,
  input  wire logic   sda_in,
  imadc_line_if.mon   line
);
  logic [2:0] scl_s;
  logic [2:0] sda_s;

  // ==========================================================
  // synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
    end else begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
    end
  end

  assign line.scl       = scl_s[1];
  assign line.sda       = sda_s[1];
  // conditions judged on stages 1 and 2 only
  assign line.start_det = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
  assign line.stop_det  = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
endmodule : imadc_line_mon

// file: src/imadc_baud.sv
// imadc_baud: quarter-bit tick divider for standard and high-speed rates.
// assumes run/halt/hs come from logic on hclk.
`timescale 1ns/1ns
module imadc_baud #(
  parameter int STD_QTR = 250,
  parameter int HS_QTR  = 7
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic run,
  input  wire logic halt,
  input  wire logic hs,
  output logic      tick
);
  localparam logic [8:0] STD_LIM = 9'(STD_QTR - 1);
  localparam logic [8:0] HS_LIM  = 9'(HS_QTR - 1);
  logic [8:0] cnt_q;

  // ==========================================================
  // divider; a halt freezes the count so the bit resumes where it stood
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 9'h000;
      tick  <= 1'b0;
    end else if (!run) begin
      cnt_q <= 9'h000;
      tick  <= 1'b0;
    end else if (halt) begin
      tick  <= 1'b0;
    end else if (cnt_q >= (hs ? HS_LIM : STD_LIM)) begin
      cnt_q <= 9'h000;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 9'h001;
      tick  <= 1'b0;
    end
  end
endmodule : imadc_baud

// file: src/imadc_top.sv
// imadc_top: i2c master address/data control behind an ahb-lite slave.
// assumes open-drain pads outside and a cpu debug halt level on hclk.
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ns
module imadc_top
  import imadc_pkg::*;
#(
  parameter int SCL_LOW_TIMEOUT_FLAG_CYCLES = imadc_pkg::SCL_LOW_TIMEOUT_FLAG_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        cpu_debug_halt,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_n,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n
);
  import imadc_pkg::*;

  imadc_line_if line ();
  imadc_state_t st_q;
  logic        wr_pend_q, rd_pend_q;
  logic [7:0]  waddr_q, raddr_q;
  logic [31:0] ctrl_q, addr_q, rmux;
  logic [7:0]  dbg_q, data_q, sh_q, sh2_q, cnt_q, cnt_inc;
  logic [1:0]  ph_q, nx_q, bstate_q, sync_q;
  logic [2:0]  bit_q;
  logic        addr_left_q, rw_q, lost_q, ack_val_q, in_addr_q, rs_q, hs_act_q, nack_q;
  logic        set_mb_q, set_sb_q, set_berr_q, set_arb_q, own_go_q, stop_done_q, lose_q;
  logic        mb_q, sb_q, berr_q, arb_q, lowt_q, to_p;
  logic [31:0] lowt_cnt_q;
  logic        tick, scl_low, sda_low, enable, smen, ackact, auto_count_enable;
  logic        addr_wr_p, data_wr_p, data_rd_p, ctrl_wr_p, int_wr_p, st_wr_p;
  logic [1:0]  cmd_p;
  logic [7:0]  first_b, second_b;

  assign enable  = ctrl_q[CTRL_ENABLE_BIT];
  assign smen    = ctrl_q[CTRL_SMEN_BIT];
  assign ackact  = ctrl_q[CTRL_ACKACT_BIT];
  assign auto_count_enable   = addr_q[ADDR_AUTO_COUNT_ENABLE_BIT];
  assign cnt_inc = cnt_q + 8'h01;

  imadc_line_mon u_mon (
    .hclk    (hclk),
    .hresetn (hresetn),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .line    (line)
  );

  imadc_baud #(
    .STD_QTR (STD_QTR_CYC),
    .HS_QTR  (HS_QTR_CYC)
  ) u_baud (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (enable),
    .halt    (dbg_q[0] & cpu_debug_halt),
    .hs      (hs_act_q),
    .tick    (tick)
  );

  // ==========================================================
  // ahb-lite slave: writes take effect in their data phase,
  // reads add one wait state so they see any preceding write
  wire take = hsel & htrans[1] & hready & (hsize == 3'h2);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      waddr_q   <= 8'h00;
      raddr_q   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
    end else begin
      wr_pend_q <= take & hwrite;
      if (take) begin
        waddr_q <= haddr[7:0];
        raddr_q <= haddr[7:0];
      end
      if (take & !hwrite) begin
        rd_pend_q <= 1'b1;
        hreadyout <= 1'b0;
      end else if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
        hreadyout <= 1'b1;
        hrdata    <= rmux;
      end
    end
  end

  wire wr_on = wr_pend_q; // upper address bits ignored, map repeats
  assign addr_wr_p = wr_on & (waddr_q == OFF_ADDR);
  assign data_wr_p = wr_on & (waddr_q == OFF_DATA);
  assign ctrl_wr_p = wr_on & (waddr_q == OFF_CTRL);
  assign int_wr_p  = wr_on & (waddr_q == OFF_INTFLAG);
  assign st_wr_p   = wr_on & (waddr_q == OFF_STATUS);
  assign data_rd_p = rd_pend_q & (raddr_q == OFF_DATA);
  assign cmd_p     = ctrl_wr_p ? hwdata[CTRL_CMD_LSB +: 2] : 2'h0;

  // reserved bits read as zero; unmapped offsets read as zero
  always_comb begin
    rmux = 32'h00000000;
    case (raddr_q)
      OFF_CTRL:     rmux = ctrl_q;
      OFF_INTFLAG:  rmux = {30'h0, sb_q, mb_q};
      OFF_STATUS:   rmux = {24'h0, (st_q == S_HOLD), lowt_q, bstate_q, 1'b0, nack_q,
                            arb_q, berr_q};
      OFF_DATA:     rmux = {24'h0, data_q};
      OFF_SYNCBUSY: rmux = {29'h0, (sync_q != 2'h0), 2'h0};
      OFF_ADDR:     rmux = addr_q & ADDR_WR_MASK;
      OFF_DEBUG_HALT_CONTROL:  rmux = {24'h0, dbg_q};
      default:      rmux = 32'h00000000;
    endcase
  end

  // ==========================================================
  // control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= CTRL_RST;
      addr_q <= ADDR_RST;
      dbg_q  <= DEBUG_HALT_CONTROL_RST;
    end else begin
      if (ctrl_wr_p) begin
        ctrl_q <= hwdata & 32'h00040102;
      end
      if (addr_wr_p) begin
        addr_q <= hwdata & ADDR_WR_MASK;
      end
      if (wr_on & (waddr_q == OFF_DEBUG_HALT_CONTROL)) begin
        dbg_q <= {7'h00, hwdata[0]};
      end
    end
  end

  // address bytes: 7-bit sends addr[7:0]; wide sends prefix then addr[8:1]
  assign first_b  = hwdata[ADDR_WIDE_BIT] ? {TEN_BIT_PREFIX, hwdata[10:9], hwdata[0]}
                                          : hwdata[7:0];
  assign second_b = hwdata[8:1];

  // ==========================================================
  // bus sequencer; each bit is four quarter-bit ticks
  wire active = (st_q == S_START) | (st_q == S_TXB) | (st_q == S_TXACK) |
                (st_q == S_RXB) | (st_q == S_RXACK) | (st_q == S_STOP);
  wire adv  = tick & active & !((ph_q == 2'h1) & !line.scl); // slave stretch
  wire samp = adv & (ph_q == 2'h2);
  wire fin  = adv & (ph_q == 2'h3);
  wire bit_drive = !(lost_q | sh_q[7]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= S_IDLE;
      {ph_q, bit_q, nx_q} <= 7'h00;
      {sh_q, sh2_q, cnt_q, data_q} <= {24'h000000, DATA_RST};
      {addr_left_q, rw_q, lost_q, ack_val_q, in_addr_q, rs_q, hs_act_q, nack_q} <= 8'h00;
      {set_mb_q, set_sb_q, set_berr_q, set_arb_q, own_go_q, stop_done_q, lose_q} <= 7'h00;
    end else begin
      {set_mb_q, set_sb_q, set_berr_q, set_arb_q, own_go_q, stop_done_q, lose_q} <= 7'h00;
      if (adv) begin
        ph_q <= ph_q + 2'h1;
      end
      if (data_wr_p) begin
        data_q <= hwdata[7:0];
      end
      if (addr_wr_p && (st_q == S_IDLE || st_q == S_WAIT || st_q == S_HOLD)) begin
        sh_q <= first_b;
        sh2_q <= second_b;
        addr_left_q <= hwdata[ADDR_WIDE_BIT];
        rw_q <= hwdata[0];
        lost_q <= 1'b0;
        in_addr_q <= 1'b1;
        cnt_q <= 8'h00;
        hs_act_q <= hwdata[ADDR_HS_BIT];
        rs_q <= (st_q == S_HOLD);
      end
      if (!enable) begin
        st_q <= S_IDLE;
        ph_q <= 2'h0;
      end else begin
        case (st_q)
          S_IDLE: begin
            if (addr_wr_p) begin
              if (bstate_q == BS_UNKNOWN) begin
                set_mb_q   <= 1'b1;
                set_berr_q <= 1'b1;
              end else if (bstate_q == BS_BUSY) begin
                st_q <= S_WAIT;
              end else begin
                st_q <= S_START;
                own_go_q <= 1'b1;
              end
            end
          end
          S_WAIT: begin
            if (bstate_q == BS_IDLE) begin
              st_q <= S_START;
              own_go_q <= 1'b1;
            end
          end
          S_HOLD: begin
            if (addr_wr_p) begin
              if (rw_q) begin
                ack_val_q <= ackact;
                nx_q <= NX_START;
                st_q <= S_RXACK;
              end else begin
                st_q <= S_START;
              end
            end else if (cmd_p == CMD_STOP) begin
              ack_val_q <= ackact;
              nx_q <= NX_STOP;
              st_q <= rw_q ? S_RXACK : S_STOP;
            end else if (rw_q && ((data_rd_p && smen) || cmd_p == CMD_READ)) begin
              ack_val_q <= ackact;
              nx_q <= (smen & ackact & data_rd_p) ? NX_STOP : NX_RXB;
              st_q <= S_RXACK;
            end else if (!rw_q && data_wr_p) begin
              sh_q <= hwdata[7:0];
              st_q <= S_TXB;
            end
          end
          S_START: begin
            if (fin) begin
              st_q <= S_TXB;
              bit_q <= 3'h0;
            end
          end
          S_TXB: begin
            if (samp && !bit_drive && !line.sda) begin
              lost_q    <= 1'b1;
              set_arb_q <= 1'b1;
              set_mb_q  <= 1'b1;
            end
            if (fin) begin
              sh_q  <= {sh_q[6:0], 1'b0};
              bit_q <= bit_q + 3'h1;
              if (bit_q == 3'h7) begin
                st_q <= S_TXACK;
              end
            end
          end
          S_TXACK: begin
            if (samp) begin
              nack_q <= line.sda;
            end
            if (fin) begin
              if (!in_addr_q) begin
                cnt_q <= cnt_inc;
              end
              if (lost_q) begin
                st_q <= S_IDLE;
                lose_q <= 1'b1;
              end else if (addr_left_q) begin
                sh_q <= sh2_q;
                addr_left_q <= 1'b0;
                st_q <= S_TXB;
              end else if (in_addr_q && rw_q && !nack_q) begin
                in_addr_q <= 1'b0;
                st_q <= S_RXB;
              end else if (!in_addr_q && auto_count_enable && cnt_inc == addr_q[ADDR_LEN_LSB +: 8]) begin
                st_q <= S_STOP;
              end else begin
                in_addr_q <= 1'b0;
                st_q <= S_HOLD;
                set_mb_q <= 1'b1;
              end
            end
          end
          S_RXB: begin
            if (samp) begin
              sh_q <= {sh_q[6:0], line.sda};
            end
            if (fin) begin
              bit_q <= bit_q + 3'h1;
              if (bit_q == 3'h7) begin
                data_q <= sh_q;
                cnt_q  <= cnt_inc;
                if (auto_count_enable && cnt_inc == addr_q[ADDR_LEN_LSB +: 8]) begin
                  ack_val_q <= 1'b1;
                  nx_q <= NX_STOP;
                  st_q <= S_RXACK;
                end else begin
                  st_q <= S_HOLD;
                  set_sb_q <= 1'b1;
                end
              end
            end
          end
          S_RXACK: begin
            if (fin) begin
              bit_q <= 3'h0;
              case (nx_q)
                NX_STOP:  st_q <= S_STOP;
                NX_START: st_q <= S_START;
                default:  st_q <= S_RXB;
              endcase
            end
          end
          S_STOP: begin
            if (fin) begin
              st_q <= S_IDLE;
              hs_act_q <= 1'b0;
              stop_done_q <= 1'b1;
            end
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // pin drive per state and quarter
  always_comb begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    case (st_q)
      S_START: begin
        scl_low = (ph_q == 2'h3) | ((ph_q == 2'h0) & rs_q);
        sda_low = ph_q[1];
      end
      S_TXB: begin
        scl_low = (ph_q == 2'h0) | (ph_q == 2'h3);
        sda_low = bit_drive;
      end
      S_TXACK, S_RXB: scl_low = (ph_q == 2'h0) | (ph_q == 2'h3);
      S_RXACK: begin
        scl_low = (ph_q == 2'h0) | (ph_q == 2'h3);
        sda_low = !ack_val_q;
      end
      S_STOP: begin
        scl_low = (ph_q == 2'h0);
        sda_low = !ph_q[1];
      end
      S_HOLD:  scl_low = 1'b1;
      default: scl_low = 1'b0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      scl_out  <= 1'b0;
      sda_out  <= 1'b0;
    end else begin
      scl_oe_n <= !(scl_low & enable);
      sda_oe_n <= !(sda_low & enable);
    end
  end

  // ==========================================================
  // bus ownership tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bstate_q <= BS_UNKNOWN;
    end else if (!enable) begin
      bstate_q <= BS_UNKNOWN;
    end else if (own_go_q) begin
      bstate_q <= BS_OWNER;
    end else if (stop_done_q || line.stop_det) begin
      bstate_q <= BS_IDLE;
    end else if (lose_q || (line.start_det && bstate_q != BS_OWNER)) begin
      bstate_q <= BS_BUSY;
    end else if (st_wr_p && bstate_q == BS_UNKNOWN &&
                 hwdata[ST_BUS_OWNERSHIP_STATE_LSB +: 2] == BS_IDLE) begin
      bstate_q <= BS_IDLE;
    end
  end

  // ==========================================================
  // flags: hardware set wins over any clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {mb_q, sb_q, berr_q, arb_q, lowt_q} <= 5'h00;
    end else begin
      if (set_mb_q) mb_q <= 1'b1;
      else if (addr_wr_p || (int_wr_p && hwdata[INT_MB_BIT])) mb_q <= 1'b0;
      if (set_sb_q) sb_q <= 1'b1;
      else if (addr_wr_p || (int_wr_p && hwdata[INT_SB_BIT])) sb_q <= 1'b0;
      if (set_berr_q || to_p) berr_q <= 1'b1;
      else if (addr_wr_p || (st_wr_p && hwdata[ST_BUSERR_BIT])) berr_q <= 1'b0;
      if (set_arb_q) arb_q <= 1'b1;
      else if (addr_wr_p || (st_wr_p && hwdata[ST_ARBLOST_BIT])) arb_q <= 1'b0;
      if (to_p) lowt_q <= 1'b1;
      else if (addr_wr_p || (st_wr_p && hwdata[ST_SCL_LOW_TIMEOUT_FLAG_BIT])) lowt_q <= 1'b0;
    end
  end

  // scl low watchdog; counts our own hold too, so long holds also trip it
  assign to_p = enable && !line.scl && (lowt_cnt_q == 32'(SCL_LOW_TIMEOUT_FLAG_CYCLES - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lowt_cnt_q <= 32'h00000000;
    end else if (!enable || line.scl) begin
      lowt_cnt_q <= 32'h00000000;
    end else if (lowt_cnt_q != 32'(SCL_LOW_TIMEOUT_FLAG_CYCLES)) begin
      lowt_cnt_q <= lowt_cnt_q + 32'h00000001;
    end
  end

  // sync busy shown only; effects apply at once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_q <= 2'h0;
    end else if (enable && (addr_wr_p || (data_wr_p && smen))) begin
      sync_q <= SYNC_CYC;
    end else if (sync_q != 2'h0) begin
      sync_q <= sync_q - 2'h1;
    end
  end

endmodule : imadc_top

// file: testbench/imadc_monitor.sv
// imadc_monitor: port checks on the register bus and the i2c pads.
// assumes a bind to imadc_top, one hclk domain.
`timescale 1ns/1ns
module imadc_monitor (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        scl_out,
  input wire logic        scl_oe_n,
  input wire logic        sda_out,
  input wire logic        sda_oe_n
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take;
  assign take = hsel && htrans[1] && hready && hsize == 3'h2;
  // =====
  // bus answer
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  a_write_fast: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_wait_once: assert property (!hreadyout |=> hreadyout)
    else $error("wait too long");
  a_wait_cause: assert property ($fell(hreadyout) |-> $past(take && !hwrite))
    else $error("stray wait state");
  a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved");
  // =====
  // pads: open drain, so only the enables may move
  a_pads_low: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("pad driven high");
  a_scl_spacing: assert property ($changed(scl_oe_n) |=> $stable(scl_oe_n) [*6])
    else $error("scl edge too soon");
  c_read: cover property (take && !hwrite);
  c_scl: cover property ($fell(scl_oe_n));
  c_sda: cover property ($fell(sda_oe_n));
endmodule : imadc_monitor

bind imadc_top imadc_monitor imadc_monitor_inst (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scl_out(scl_out),
  .scl_oe_n(scl_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n));

// file: testbench/imadc_slave_model.sv
// imadc_slave_model: i2c target that acks every byte and reports it.
// assumes wired-and line levels with a pull-up.
`timescale 1ns/1ns
module imadc_slave_model (
  input  wire logic scl,
  input  wire logic sda,
  output logic       sda_oe_n,
  output logic [7:0] rx_byte,
  output logic       rx_v
);
  int         cnt;
  logic [7:0] sh;
  initial begin
    sda_oe_n = 1'b1;
    rx_v = 1'b0;
    rx_byte = 8'h00;
    cnt = 0;
  end
  // a start restarts the bit count
  always @(negedge sda) if (scl) cnt = 0;
  always @(posedge scl) if (cnt < 8) begin
    sh = {sh[6:0], sda};
    cnt = cnt + 1;
  end
  always @(negedge scl) begin
    rx_v = 1'b0;
    if (cnt == 8) begin
      sda_oe_n = 1'b0;
      cnt = 9;
    end else if (cnt == 9) begin
      sda_oe_n = 1'b1;
      cnt = 0;
      rx_byte = sh;
      rx_v = 1'b1;
    end
  end
endmodule : imadc_slave_model

// file: testbench/test_i2c_master_address_data_ctrl.sv
// test_i2c_master_address_data_ctrl: ahb master, i2c target, checks.
// assumes the design package and a pulled-up open-drain bus.
`timescale 1ns/1ns
module test_i2c_master_address_data_ctrl;
  import imadc_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, halt, dph_rd;
  logic [31:0] haddr, hwdata, q;
  logic [1:0]  htrans, s;
  logic [2:0]  hsize;
  logic [15:0] r;
  logic [31:0] exp_q[$];
  logic [7:0]  wq[$];
  int          fails, n_checks, cyc;
  wire logic        hreadyout, hresp, scl_oe_n, sda_oe_n, s_oe_n, rx_v;
  wire logic [31:0] hrdata;
  wire logic [7:0]  rx_byte;
  wire logic        scl_w = scl_oe_n;
  wire logic        sda_w = sda_oe_n & s_oe_n;
  imadc_top imadc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cpu_debug_halt(halt),
    .scl_in(scl_w), .scl_out(), .scl_oe_n(scl_oe_n), .sda_in(sda_w), .sda_out(),
    .sda_oe_n(sda_oe_n));
  imadc_slave_model imadc_slave_model_inst (.scl(scl_w), .sda(sda_w),
    .sda_oe_n(s_oe_n), .rx_byte(rx_byte), .rx_v(rx_v));
  // =====
  // tasks
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    dph_rd <= !w && c;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    dph_rd <= 1'b0;
  endtask : ahb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    ahb(1'b0, a, 32'h0, 1'b1);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, 1'b0);
  endtask : wr
  // polls are spaced out; a byte takes thousands of cycles
  task automatic wait_mb;
    q = 32'h0;
    for (int i = 0; i < 300 && q[0] !== 1'b1; i++) begin
      repeat (100) @(posedge hclk);
      ahb(1'b0, OFF_INTFLAG, 32'h0, 1'b0);
    end
  endtask : wait_mb
  // =====
  // watchers and timeout
  always @(posedge hclk) if (dph_rd && hreadyout === 1'b1) check(hrdata, exp_q.pop_front());
  always @(posedge rx_v) check({24'h0, rx_byte}, {24'h0, wq.pop_front()});
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      stop_test();
    end
  end
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // =====
  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    hsize = 3'h2;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    halt = 1'b0;
    dph_rd = 1'b0;
    r = 16'h9607;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(OFF_ADDR, ADDR_RST);
    rd(OFF_DATA, {24'h0, DATA_RST});
    wr(OFF_CTRL, 32'h2);
    wr(OFF_ADDR, 32'hffffffff);
    rd(OFF_SYNCBUSY, 32'h4);
    repeat (4) @(posedge hclk);
    rd(OFF_STATUS, 32'h1);
    rd(OFF_INTFLAG, 32'h1);
    rd(OFF_ADDR, ADDR_WR_MASK);
    rd(OFF_ADDR, ADDR_WR_MASK);
    rd(OFF_STATUS, 32'h1);
    wr(OFF_DEBUG_HALT_CONTROL, 32'hffffffff);
    rd(OFF_DEBUG_HALT_CONTROL, 32'h1);
    rd(8'h0c, 32'h0);
    wr(OFF_STATUS, 32'h10);
    r = lfsr(r);
    wq.push_back({r[6:0], 1'b0});
    wr(OFF_ADDR, {24'h0, r[6:0], 1'b0});
    wait_mb();
    rd(OFF_STATUS, 32'ha0);
    wr(OFF_INTFLAG, 32'h1);
    wq.push_back(r[15:8]);
    wr(OFF_DATA, {24'h0, r[15:8]});
    repeat (300) @(posedge hclk);
    halt <= 1'b1;
    repeat (2) @(posedge hclk);
    s = {scl_oe_n, sda_oe_n};
    repeat (2000) @(posedge hclk);
    check({30'h0, scl_oe_n, sda_oe_n}, {30'h0, s});
    halt <= 1'b0;
    wait_mb();
    rd(OFF_DATA, {24'h0, r[15:8]});
    // repeated start while the master flag stands: wide address, auto count of one
    wq.push_back(8'hf2);
    wq.push_back(8'h52);
    wr(OFF_ADDR, 32'h1a2a4);
    wait_mb();
    rd(OFF_ADDR, 32'h1a2a4);
    r = lfsr(r);
    wq.push_back(r[7:0]);
    wr(OFF_DATA, {24'h0, r[7:0]});
    repeat (12000) @(posedge hclk);
    rd(OFF_STATUS, 32'h10);
    check(32'(wq.size()), 32'h0);
    stop_test();
  end
endmodule : test_i2c_master_address_data_ctrl
